// ===== pulse_counter_pkg.sv
package pulse_counter_pkg;

    // =====================================================================
    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CHAN_STRIDE_LSB = 6;
    localparam int REG_IDX_LSB = 2;
    localparam int REG_IDX_W = 4;

    // =====================================================================
    // register map: word indices inside one channel window of 0x40 bytes
    localparam logic [REG_IDX_W-1:0] REG_CONFIG = 4'h0;
    localparam logic [REG_IDX_W-1:0] REG_START_CFG = 4'h1;
    localparam logic [REG_IDX_W-1:0] REG_WRAP_CFG = 4'h2;
    localparam logic [REG_IDX_W-1:0] REG_START_OVR = 4'h3;
    localparam logic [REG_IDX_W-1:0] REG_WRAP_OVR = 4'h4;
    localparam logic [REG_IDX_W-1:0] REG_CONTROL = 4'h5;
    localparam logic [REG_IDX_W-1:0] REG_COUNT = 4'h6;
    localparam logic [REG_IDX_W-1:0] REG_CAPTURED = 4'h7;
    localparam logic [REG_IDX_W-1:0] REG_RATE = 4'h8;

    // =====================================================================
    // field positions of the configuration and control words
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_MODE_W = 2;
    localparam int CFG_STORE_LSB = 2;
    localparam int CFG_STORE_W = 3;
    localparam int CFG_INV_BIT = 5;
    localparam int CTRL_LOAD_BIT = 0;

    // =====================================================================
    // counting modes and store modes
    typedef enum logic [1:0]
    {
        MODE_PLAIN = 2'h0,
        MODE_SINGLE_EDGE = 2'h1,
        MODE_FOUR_EDGE = 2'h2
    } count_mode_t;

    typedef enum logic [2:0]
    {
        STORE_NONE = 3'h0,
        STORE_CONTINUE = 3'h1,
        STORE_WAIT_RESUME = 3'h2,
        STORE_RESET_WAIT_START = 3'h3,
        STORE_RESET_START = 3'h4
    } store_mode_t;

    // =====================================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int RATE_WINDOW_US = 1000;
    localparam int RATE_WINDOW_CYCLES = RATE_WINDOW_US * 1000 / CLK_PERIOD_NS;

endpackage

// ===== pulse_encoder_counter_capture.sv
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module pulse_encoder_counter_capture
#(
    parameter int NUM_CH = 2,
    parameter int COUNT_W = 32,
    parameter int RATE_CYCLES = pulse_counter_pkg::RATE_WINDOW_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pulse_counter_pkg::ADDR_W-1:0] paddr,
    input wire logic [pulse_counter_pkg::DATA_W-1:0] pwdata,
    output logic [pulse_counter_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_CH-1:0] countIn,
    input wire logic [NUM_CH-1:0] dirIn,
    input wire logic [NUM_CH-1:0] gateIn
);
    import pulse_counter_pkg::*;

    // =====================================================================
    // elaboration checks
    if (NUM_CH < 1 || NUM_CH > 4)
        $error("NUM_CH must be 1 to 4");
    if (COUNT_W < 2 || COUNT_W > DATA_W)
        $error("COUNT_W must be 2 to 32");
    if (RATE_CYCLES < 2)
        $error("RATE_CYCLES must be at least 2");

    // =====================================================================
    // state
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] prevIn;
        logic prevActive;
        count_mode_t mode;
        store_mode_t store;
        logic invGate;
        logic [COUNT_W-1:0] startCfg;
        logic [COUNT_W-1:0] wrapCfg;
        logic [COUNT_W-1:0] startOvr;
        logic [COUNT_W-1:0] wrapOvr;
        logic [COUNT_W-1:0] count;
        logic [COUNT_W-1:0] captured;
        logic loadReq;
        logic pendValid;
        logic pendUp;
        logic [COUNT_W-1:0] rateAcc;
        logic [COUNT_W-1:0] rate;
    } chan_t;

    typedef struct packed {
        chan_t [NUM_CH-1:0] ch;
        logic [31:0] winCnt;
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;

    localparam logic [31:0] WIN_LAST = 32'(RATE_CYCLES - 1);
    localparam logic [COUNT_W-1:0] CNT_ZERO = '0;
    localparam logic [COUNT_W-1:0] CNT_ONE = COUNT_W'(1);

    state_t state_ff;
    state_t nxt_state;

    logic [NUM_CH-1:0] rawStep;
    logic [NUM_CH-1:0] rawUp;
    logic [NUM_CH-1:0] capEvent;
    logic [NUM_CH-1:0] frozen;
    logic [NUM_CH-1:0] applied;
    logic [COUNT_W-1:0] startVal [NUM_CH];
    logic [COUNT_W-1:0] wrapVal [NUM_CH];
    logic winEnd;
    logic accessEnd;

    // =====================================================================
    // helpers
    // a zero limit means no wrap limit at all: the count runs over its full width
    function automatic logic [COUNT_W-1:0] stepCount(
        input logic [COUNT_W-1:0] cnt,
        input logic up,
        input logic [COUNT_W-1:0] lim
    );
        logic [COUNT_W-1:0] res;
        res = cnt;
        if (up)
        begin
            if (lim != CNT_ZERO && cnt + CNT_ONE >= lim)
                res = CNT_ZERO;
            else
                res = cnt + CNT_ONE;
        end
        else
        begin
            if (cnt == CNT_ZERO)
                res = (lim != CNT_ZERO) ? lim - CNT_ONE : '1;
            else
                res = cnt - CNT_ONE;
        end
        return res;
    endfunction

    function automatic logic [COUNT_W-1:0] pickOverride(
        input logic [COUNT_W-1:0] cfg,
        input logic [COUNT_W-1:0] ovr
    );
        return (ovr != CNT_ZERO) ? ovr : cfg;
    endfunction

    function automatic logic badAddr(input logic [ADDR_W-1:0] a);
        logic bad;
        bad = (a[REG_IDX_LSB-1:0] != '0);
        bad = bad || (a[CHAN_STRIDE_LSB-1:REG_IDX_LSB] > REG_RATE);
        bad = bad || (32'(a >> CHAN_STRIDE_LSB) >= NUM_CH);
        return bad;
    endfunction

    function automatic logic [DATA_W-1:0] readReg(
        input chan_t c,
        input logic [REG_IDX_W-1:0] idx
    );
        logic [DATA_W-1:0] d;
        d = '0;
        case (idx)
            REG_CONFIG:
            begin
                d[CFG_MODE_LSB +: CFG_MODE_W] = c.mode;
                d[CFG_STORE_LSB +: CFG_STORE_W] = c.store;
                d[CFG_INV_BIT] = c.invGate;
            end
            REG_START_CFG: d[COUNT_W-1:0] = c.startCfg;
            REG_WRAP_CFG: d[COUNT_W-1:0] = c.wrapCfg;
            REG_START_OVR: d[COUNT_W-1:0] = c.startOvr;
            REG_WRAP_OVR: d[COUNT_W-1:0] = c.wrapOvr;
            REG_COUNT: d[COUNT_W-1:0] = c.count;
            REG_CAPTURED: d[COUNT_W-1:0] = c.captured;
            REG_RATE: d = DATA_W'($signed(c.rate));
            default: d = '0;
        endcase
        return d;
    endfunction

    // =====================================================================
    // next state
    always_comb
    begin
        logic [2:0] cur;
        logic [2:0] old;
        logic aRise;
        logic aFall;
        logic aEdge;
        logic bEdge;
        logic active;
        logic resetMode;
        logic stepNow;
        logic stepUp;
        int ci;
        logic [REG_IDX_W-1:0] ri;
        cur = '0;
        old = '0;
        aRise = 1'b0;
        aFall = 1'b0;
        aEdge = 1'b0;
        bEdge = 1'b0;
        active = 1'b0;
        resetMode = 1'b0;
        stepNow = 1'b0;
        stepUp = 1'b0;
        ci = 32'(paddr >> CHAN_STRIDE_LSB);
        ri = paddr[CHAN_STRIDE_LSB-1:REG_IDX_LSB];
        nxt_state = state_ff;
        nxt_state.pready = 1'b0;
        nxt_state.pslverr = 1'b0;
        accessEnd = psel && penable && state_ff.pready;
        winEnd = (state_ff.winCnt == WIN_LAST);
        nxt_state.winCnt = winEnd ? '0 : state_ff.winCnt + 32'h0000_0001;

        // one wait state: the answer is prepared in the first access cycle
        if (psel && penable && !state_ff.pready)
        begin
            nxt_state.pready = 1'b1;
            nxt_state.pslverr = badAddr(paddr);
            nxt_state.prdata = '0;
            if (!badAddr(paddr) && !pwrite)
                nxt_state.prdata = readReg(state_ff.ch[ci], ri);
        end

        for (int i = 0; i < NUM_CH; i++)
        begin
            nxt_state.ch[i].sync1 = {gateIn[i], dirIn[i], countIn[i]};
            nxt_state.ch[i].sync2 = state_ff.ch[i].sync1;
            nxt_state.ch[i].prevIn = state_ff.ch[i].sync2;
            cur = state_ff.ch[i].sync2;
            old = state_ff.ch[i].prevIn;
            aRise = cur[0] && !old[0];
            aFall = !cur[0] && old[0];
            aEdge = cur[0] ^ old[0];
            bEdge = cur[1] ^ old[1];

            case (state_ff.ch[i].mode)
                MODE_SINGLE_EDGE:
                begin
                    rawStep[i] = cur[1] && (aRise || aFall);
                    rawUp[i] = aRise;
                end
                MODE_FOUR_EDGE:
                begin
                    rawStep[i] = aEdge || bEdge;
                    rawUp[i] = aEdge ? (cur[0] == cur[1]) : (cur[1] != cur[0]);
                end
                default:
                begin
                    rawStep[i] = aRise;
                    rawUp[i] = !cur[1];
                end
            endcase

            active = cur[2] ^ state_ff.ch[i].invGate;
            nxt_state.ch[i].prevActive = active;
            capEvent[i] = (state_ff.ch[i].store inside {[STORE_CONTINUE:STORE_RESET_START]})
                && active && !state_ff.ch[i].prevActive;
            resetMode = (state_ff.ch[i].store == STORE_RESET_WAIT_START)
                || (state_ff.ch[i].store == STORE_RESET_START);
            frozen[i] = active && ((state_ff.ch[i].store == STORE_WAIT_RESUME)
                || (state_ff.ch[i].store == STORE_RESET_WAIT_START));
            startVal[i] = pickOverride(state_ff.ch[i].startCfg, state_ff.ch[i].startOvr);
            wrapVal[i] = pickOverride(state_ff.ch[i].wrapCfg, state_ff.ch[i].wrapOvr);

            // capture only on active gate edge
            if (capEvent[i])
                nxt_state.ch[i].captured = state_ff.ch[i].count;

            applied[i] = 1'b0;
            stepNow = 1'b0;
            stepUp = 1'b0;
            nxt_state.ch[i].pendValid = 1'b0;
            nxt_state.ch[i].loadReq = 1'b0;
            if (state_ff.ch[i].loadReq)
            begin
                // load start value; edge deferred one cycle
                nxt_state.ch[i].count = startVal[i];
                nxt_state.ch[i].pendValid = rawStep[i];
                nxt_state.ch[i].pendUp = rawUp[i];
            end
            else if (capEvent[i] && resetMode)
            begin
                nxt_state.ch[i].count = CNT_ZERO;
            end
            else if (!frozen[i])
            begin
                // a deferred edge goes first, a fresh one queues behind it
                if (state_ff.ch[i].pendValid)
                begin
                    stepNow = 1'b1;
                    stepUp = state_ff.ch[i].pendUp;
                    nxt_state.ch[i].pendValid = rawStep[i];
                    nxt_state.ch[i].pendUp = rawUp[i];
                end
                else
                begin
                    stepNow = rawStep[i];
                    stepUp = rawUp[i];
                end
                if (stepNow)
                begin
                    nxt_state.ch[i].count = stepCount(state_ff.ch[i].count, stepUp,
                        wrapVal[i]);
                    applied[i] = 1'b1;
                end
            end

            nxt_state.ch[i].rateAcc = state_ff.ch[i].rateAcc;
            if (winEnd)
            begin
                nxt_state.ch[i].rate = state_ff.ch[i].rateAcc;
                nxt_state.ch[i].rateAcc = CNT_ZERO;
            end
            if (applied[i])
                nxt_state.ch[i].rateAcc = nxt_state.ch[i].rateAcc
                    + (stepUp ? CNT_ONE : '1);
        end

        // writes land on the completing edge only
        if (accessEnd && pwrite && !badAddr(paddr))
        begin
            case (ri)
                REG_CONFIG:
                begin
                    nxt_state.ch[ci].mode = count_mode_t'(pwdata[CFG_MODE_LSB +: CFG_MODE_W]);
                    nxt_state.ch[ci].store = store_mode_t'(pwdata[CFG_STORE_LSB +: CFG_STORE_W]);
                    nxt_state.ch[ci].invGate = pwdata[CFG_INV_BIT];
                end
                REG_START_CFG: nxt_state.ch[ci].startCfg = pwdata[COUNT_W-1:0];
                REG_WRAP_CFG: nxt_state.ch[ci].wrapCfg = pwdata[COUNT_W-1:0];
                REG_START_OVR: nxt_state.ch[ci].startOvr = pwdata[COUNT_W-1:0];
                REG_WRAP_OVR: nxt_state.ch[ci].wrapOvr = pwdata[COUNT_W-1:0];
                REG_CONTROL: nxt_state.ch[ci].loadReq = pwdata[CTRL_LOAD_BIT];
                default: nxt_state.ch[ci].loadReq = nxt_state.ch[ci].loadReq;
            endcase
        end
    end

    // =====================================================================
    // registers
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    assign prdata = state_ff.prdata;
    assign pready = state_ff.pready;
    assign pslverr = state_ff.pslverr;

    // =====================================================================
    // assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("pready not a single pulse after one wait");

    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_chk
        load_apply_a: assert property (state_ff.ch[g].loadReq
            |=> state_ff.ch[g].count == $past(startVal[g]))
            else $error("load did not copy start value");
        load_defer_a: assert property (state_ff.ch[g].loadReq && rawStep[g]
            |=> state_ff.ch[g].pendValid)
            else $error("edge lost under load");
        capture_hold_a: assert property ($changed(state_ff.ch[g].captured)
            |-> $past(capEvent[g]))
            else $error("captured count changed without gate edge");
        gate_clear_a: assert property (capEvent[g] && !state_ff.ch[g].loadReq
            && state_ff.ch[g].store inside {STORE_RESET_WAIT_START, STORE_RESET_START}
            |=> state_ff.ch[g].count == '0)
            else $error("count not cleared on gate edge");
        freeze_hold_a: assert property (frozen[g] && !state_ff.ch[g].loadReq
            && !capEvent[g] |=> $stable(state_ff.ch[g].count))
            else $error("count moved while frozen");
        gate_idle_a: assert property (
            !(state_ff.ch[g].store inside {[STORE_CONTINUE:STORE_RESET_START]})
            |=> $stable(state_ff.ch[g].captured))
            else $error("gate acted with no store mode");
        wrap_up_a: assert property (applied[g] && !state_ff.ch[g].pendValid && rawUp[g]
            && wrapVal[g] != '0 && state_ff.ch[g].count == wrapVal[g] - CNT_ONE
            |=> state_ff.ch[g].count == '0)
            else $error("no wrap to zero at limit");
        sync_path_a: assert property ($changed(state_ff.ch[g].count)
            |-> $past(applied[g] || state_ff.ch[g].loadReq || capEvent[g]))
            else $error("count changed with no cause");
        rate_sign_a: assert property (winEnd && $signed(state_ff.ch[g].rateAcc) > 0
            |=> $signed(state_ff.ch[g].rate) > 0)
            else $error("rate sign wrong");

        cover_capture_c: cover property (capEvent[g] ##[1:20] capEvent[g]);
        cover_wrap_c: cover property (applied[g] ##1 state_ff.ch[g].count == '0);
        cover_load_edge_c: cover property (state_ff.ch[g].loadReq && rawStep[g]);
    end

endmodule

// ===== encoder_source_model.sv
`timescale 1ns/1ns
// ========================================
// pulse source and quadrature encoder
module encoder_source_model
#(
    parameter int NUM_CH = 2,
    parameter int QUARTER = 100
)
(
    input wire logic clk_sys,
    output logic [NUM_CH-1:0] countIn,
    output logic [NUM_CH-1:0] dirIn
);
    logic [1:0] phase [NUM_CH];

    initial
    begin
        countIn = '0;
        dirIn = '0;
        for (int i = 0; i < NUM_CH; i++)
            phase[i] = 2'h0;
    end

    // one edge per quarter of a 250 kHz cycle at most
    task automatic hold();
        repeat (QUARTER) @(posedge clk_sys);
    endtask

    // direction level held for the whole burst
    task automatic pulses(input int ch, input logic down, input int n);
        dirIn[ch] <= down;
        repeat (n)
        begin
            hold();
            countIn[ch] <= 1'b1;
            hold();
            countIn[ch] <= 1'b0;
        end
        hold();
        dirIn[ch] <= 1'b0;
        hold();
    endtask

    // forward has the second phase leading by a quarter
    task automatic quad(input int ch, input logic fwd, input int cycles);
        repeat (4 * cycles)
        begin
            phase[ch] = fwd ? phase[ch] + 2'h1 : phase[ch] - 2'h1;
            countIn[ch] <= phase[ch][1];
            dirIn[ch] <= phase[ch][1] ^ phase[ch][0];
            hold();
        end
    endtask

    // drives the count pin alone, for an edge timed against a bus access
    task automatic level(input int ch, input logic v);
        countIn[ch] <= v;
    endtask
endmodule

// ===== tb_pulse_encoder_counter_capture.sv
`timescale 1ns/1ns
module tb_pulse_encoder_counter_capture;
    import pulse_counter_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] countIn;
    logic [1:0] dirIn;
    logic [1:0] gateIn = 2'h0;
    int fails = 0;
    int compares = 0;

    always #5 clk_sys = ~clk_sys;

    // window kept short so the rate word settles within a few encoder cycles
    pulse_encoder_counter_capture #(.NUM_CH(2), .COUNT_W(32), .RATE_CYCLES(1000)) uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .countIn(countIn), .dirIn(dirIn),
        .gateIn(gateIn));

    encoder_source_model #(.NUM_CH(2), .QUARTER(100)) src (
        .clk_sys(clk_sys), .countIn(countIn), .dirIn(dirIn));

    // ========================================
    // bus and compare helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input int ch, input logic [3:0] idx,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {4'h0, ch[1:0], idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input int ch, input logic [3:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, ch, idx, d, r, e);
    endtask

    task automatic expect_reg(input string name, input int ch, input logic [3:0] idx,
        input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, ch, idx, 32'h0000_0000, r, e);
        check(name, r, exp);
    endtask

    function automatic logic [31:0] cfgWord(count_mode_t m, store_mode_t s, logic inv);
        return 32'(m) | (32'(s) << CFG_STORE_LSB) | (32'(inv) << CFG_INV_BIT);
    endfunction

    // ========================================
    // scenarios
    task automatic test_regs();
        logic [31:0] r;
        logic e;
        for (int ch = 0; ch < 2; ch++)
            for (int i = 0; i < 9; i++)
                expect_reg("reset value", ch, 4'(i), 32'h0000_0000);
        apb(1'b0, 0, 4'h9, 32'h0000_0000, r, e);
        check("unmapped error", {31'h0000_0000, e}, 32'h0000_0001);
        check("unmapped data", r, 32'h0000_0000);
        wr(0, REG_COUNT, 32'h0000_1234);
        expect_reg("count read only", 0, REG_COUNT, 32'h0000_0000);
        wr(1, REG_WRAP_CFG, 32'hA5A5_5A5A);
        expect_reg("wrap cfg rw", 1, REG_WRAP_CFG, 32'hA5A5_5A5A);
        wr(1, REG_WRAP_CFG, 32'h0000_0000);
    endtask

    task automatic test_counting();
        src.pulses(0, 1'b0, 5);
        expect_reg("plain up", 0, REG_COUNT, 32'h0000_0005);
        src.pulses(0, 1'b1, 3);
        expect_reg("plain down", 0, REG_COUNT, 32'h0000_0002);
        expect_reg("other channel", 1, REG_COUNT, 32'h0000_0000);
        wr(1, REG_CONFIG, cfgWord(MODE_SINGLE_EDGE, STORE_NONE, 1'b0));
        src.quad(1, 1'b1, 3);
        expect_reg("x1 forward", 1, REG_COUNT, 32'h0000_0003);
        src.quad(1, 1'b0, 2);
        expect_reg("x1 reverse", 1, REG_COUNT, 32'h0000_0001);
        wr(0, REG_CONFIG, cfgWord(MODE_FOUR_EDGE, STORE_NONE, 1'b0));
        src.quad(0, 1'b1, 2);
        expect_reg("x4 forward", 0, REG_COUNT, 32'h0000_000A);
        src.quad(0, 1'b0, 3);
        expect_reg("x4 reverse", 0, REG_COUNT, 32'hFFFF_FFFE);
    endtask

    task automatic test_load_wrap();
        wr(0, REG_CONFIG, cfgWord(MODE_PLAIN, STORE_NONE, 1'b0));
        wr(0, REG_START_CFG, 32'h0000_0007);
        wr(0, REG_CONTROL, 32'h0000_0001);
        expect_reg("load cfg start", 0, REG_COUNT, 32'h0000_0007);
        wr(0, REG_START_OVR, 32'h0000_0003);
        wr(0, REG_CONTROL, 32'h0000_0001);
        expect_reg("load override", 0, REG_COUNT, 32'h0000_0003);
        expect_reg("control reads zero", 0, REG_CONTROL, 32'h0000_0000);
        wr(0, REG_WRAP_CFG, 32'h0000_0005);
        src.pulses(0, 1'b0, 3);
        expect_reg("wrap up", 0, REG_COUNT, 32'h0000_0001);
        src.pulses(0, 1'b1, 2);
        expect_reg("wrap down", 0, REG_COUNT, 32'h0000_0004);
        wr(0, REG_WRAP_OVR, 32'h0000_0008);
        src.pulses(0, 1'b0, 5);
        expect_reg("wrap override", 0, REG_COUNT, 32'h0000_0001);
        wr(0, REG_WRAP_OVR, 32'h0000_0000);
        wr(0, REG_WRAP_CFG, 32'h0000_0000);
    endtask

    task automatic test_store();
        logic [31:0] held [4] = '{32'h0000_0007, 32'h0000_0005, 32'h0000_0000, 32'h0000_0002};
        logic [31:0] after [4] = '{32'h0000_0008, 32'h0000_0006, 32'h0000_0001, 32'h0000_0003};
        logic inv;
        wr(0, REG_CONTROL, 32'h0000_0001);
        gateIn[0] <= 1'b1;
        src.pulses(0, 1'b0, 2);
        gateIn[0] <= 1'b0;
        src.pulses(0, 1'b0, 1);
        expect_reg("gate ignored count", 0, REG_COUNT, 32'h0000_0006);
        expect_reg("gate ignored capture", 0, REG_CAPTURED, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            inv = (i == 3);
            // inversion changed with no store mode, so the level swap captures nothing
            wr(0, REG_CONFIG, cfgWord(MODE_PLAIN, STORE_NONE, inv));
            gateIn[0] <= inv;
            wr(0, REG_CONTROL, 32'h0000_0001);
            wr(0, REG_CONFIG, cfgWord(MODE_PLAIN, store_mode_t'(i + 1), inv));
            src.pulses(0, 1'b0, 2);
            gateIn[0] <= ~inv;
            src.pulses(0, 1'b0, 2);
            expect_reg("captured", 0, REG_CAPTURED, 32'h0000_0005);
            expect_reg("gate active count", 0, REG_COUNT, held[i]);
            gateIn[0] <= inv;
            src.pulses(0, 1'b0, 1);
            expect_reg("gate idle count", 0, REG_COUNT, after[i]);
            expect_reg("capture held", 0, REG_CAPTURED, 32'h0000_0005);
        end
    endtask

    task automatic test_rate();
        wr(1, REG_CONFIG, cfgWord(MODE_FOUR_EDGE, STORE_NONE, 1'b0));
        src.quad(1, 1'b1, 6);
        expect_reg("rate up", 1, REG_RATE, 32'h0000_000A);
        src.quad(1, 1'b0, 6);
        expect_reg("rate down", 1, REG_RATE, 32'hFFFF_FFF6);
    endtask

    // load and a count edge meet in one cycle: the load wins, the edge follows
    task automatic test_load_edge();
        wr(0, REG_CONFIG, cfgWord(MODE_PLAIN, STORE_NONE, 1'b0));
        gateIn[0] <= 1'b0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= {4'h0, 2'h0, REG_CONTROL, 2'b00};
        pwdata <= 32'h0000_0001;
        @(posedge clk_sys);
        penable <= 1'b1;
        // the rise reaches edge detection in the cycle after the write completes
        src.level(0, 1'b1);
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        psel <= 1'b0;
        penable <= 1'b0;
        src.hold();
        src.level(0, 1'b0);
        src.hold();
        expect_reg("load then edge", 0, REG_COUNT, 32'h0000_0004);
    endtask

    task automatic finish_test();
        if (fails == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ========================================
    // sequence and watchdog
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        test_regs();
        test_counting();
        test_load_wrap();
        test_store();
        test_load_edge();
        test_rate();
        finish_test();
    end

    // the tests need about 20k cycles, so this leaves ample margin
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        fails++;
        finish_test();
    end
endmodule
